/* File: inc/rbs_regs.vh */
// Register map, field layout and voltage constants for the alternate setting bank
// ********************************************************************
// ********************************************************************
`ifndef RBS_REGS_VH
`define RBS_REGS_VH

// Register word indexes; the byte address is four times the index
`define RBS_OFS_MEM_BUCK 8'hb7
`define RBS_OFS_IO_BUCK 8'hb8
`define RBS_OFS_PERIPH_BUCK 8'hb9
`define RBS_OFS_LINEAR_ONE 8'hba
`define RBS_OFS_LINEAR_TWO 8'hbb

// Field positions
`define RBS_SLEEP_BIT 7
`define RBS_RSVD_BIT 6
`define RBS_BUCK_CODE_MSB 6
`define RBS_LIN_CODE_MSB 5

// Reset values (not given; cleared)
`define RBS_RST_VAL 8'h00

// Voltage decode in millivolts
`define RBS_BUCK_BASE_MV 16'h0320
`define RBS_LIN_BASE_MV 16'h0258
`define RBS_STEP_MV 16'h0014

// AXI responses
`define RBS_RESP_OKAY 2'b00
`define RBS_RESP_SLVERR 2'b10

`endif

/* File: hdl/rbs_code_decode.v */
// Converts a binary voltage code into a target level in millivolts
`timescale 1ns/10ps
`include "rbs_regs.vh"

module rbs_code_decode #(
    parameter CODE_W = 7,
    parameter [15:0] BASE_MV = 16'h0320
) (
    // Code in
    input wire [CODE_W-1:0] code_i,
    // Level out
    output wire [15:0] mv_o
);

    wire [15:0] code_ext;

    assign code_ext = {{(16-CODE_W){1'b0}}, code_i};
    // Product fits: 127 * 20 = 2540 stays well inside 16 bits
    assign mv_o = BASE_MV + code_ext * `RBS_STEP_MV;

endmodule

/* File: hdl/rbs_reg_byte.v */
// One byte-wide read/write setting register with a single write enable
`timescale 1ns/10ps
`include "rbs_regs.vh"

module rbs_reg_byte #(
    parameter [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_i,
    // Write port
    input wire wr_en_i,
    input wire [7:0] wr_data_i,
    // Stored value
    output wire [7:0] q_o
);

    reg [7:0] val_ff;

    always @(posedge mclk_i) begin
        if (rst_i) begin
            val_ff <= RST_VAL;
        end else if (wr_en_i) begin
            val_ff <= wr_data_i;
        end
    end

    assign q_o = val_ff;

endmodule

/* File: hdl/rbs_alt_setting_regs.v */
// Alternate (B) setting register bank for three bucks and two linear regulators
`timescale 1ns/10ps
`include "rbs_regs.vh"

module rbs_alt_setting_regs #(
    parameter ADDR_W = 10
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_i,
    // AXI4-Lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr_i,
    input wire [2:0] s_axi_awprot_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    // AXI4-Lite read address
    input wire [ADDR_W-1:0] s_axi_araddr_i,
    input wire [2:0] s_axi_arprot_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // Setting set select from the sequencer
    input wire alt_set_sel_i,
    // Memory buck
    output reg memory_buck_sleep_o,
    output reg [15:0] memory_buck_mv_o,
    output reg memory_buck_alt_active_o,
    // IO buck
    output reg io_buck_sleep_o,
    output reg [15:0] io_buck_mv_o,
    output reg io_buck_alt_active_o,
    // Peripheral buck
    output reg peripheral_buck_sleep_o,
    output reg [15:0] peripheral_buck_mv_o,
    output reg peripheral_buck_alt_active_o,
    // Linear regulator one
    output reg linear_one_sleep_o,
    output reg [15:0] linear_one_mv_o,
    output reg linear_one_alt_active_o,
    // Linear regulator two
    output reg linear_two_sleep_o,
    output reg [15:0] linear_two_mv_o,
    output reg linear_two_alt_active_o
);

    localparam NREG = 5;

    // ****************************************************************
    // Write channel
    // ****************************************************************
    reg [ADDR_W-1:0] aw_addr_ff;
    reg aw_held_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg w_held_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg [1:0] nxt_bresp;
    reg [NREG-1:0] wr_sel;
    wire wr_go;

    // Each channel is taken on its own; response waits for both
    assign s_axi_awready_o = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready_o = !w_held_ff && !bvalid_ff;
    assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;

    always @(posedge mclk_i) begin
        if (rst_i) begin
            aw_addr_ff <= {ADDR_W{1'b0}};
            aw_held_ff <= 1'b0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_addr_ff <= s_axi_awaddr_i;
            aw_held_ff <= 1'b1;
        end else if (wr_go) begin
            aw_held_ff <= 1'b0;
        end
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            w_held_ff <= 1'b0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_data_ff <= s_axi_wdata_i;
            w_strb_ff <= s_axi_wstrb_i;
            w_held_ff <= 1'b1;
        end else if (wr_go) begin
            w_held_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Offsets are word indexes, so each byte address is four times
    // the index; an ADDR_W below 10 cannot reach the bank
    localparam [ADDR_W-1:0] ADR_MEM_BUCK = {`RBS_OFS_MEM_BUCK, 2'b00};
    localparam [ADDR_W-1:0] ADR_IO_BUCK = {`RBS_OFS_IO_BUCK, 2'b00};
    localparam [ADDR_W-1:0] ADR_PERIPH_BUCK = {`RBS_OFS_PERIPH_BUCK, 2'b00};
    localparam [ADDR_W-1:0] ADR_LINEAR_ONE = {`RBS_OFS_LINEAR_ONE, 2'b00};
    localparam [ADDR_W-1:0] ADR_LINEAR_TWO = {`RBS_OFS_LINEAR_TWO, 2'b00};

    // Full compare: misaligned or unmapped addresses select nothing
    function [NREG-1:0] rbs_match;
        input [ADDR_W-1:0] addr;
        begin
            case (addr)
                ADR_MEM_BUCK: begin
                    rbs_match = 5'b00001;
                end
                ADR_IO_BUCK: begin
                    rbs_match = 5'b00010;
                end
                ADR_PERIPH_BUCK: begin
                    rbs_match = 5'b00100;
                end
                ADR_LINEAR_ONE: begin
                    rbs_match = 5'b01000;
                end
                ADR_LINEAR_TWO: begin
                    rbs_match = 5'b10000;
                end
                default: begin
                    rbs_match = {NREG{1'b0}};
                end
            endcase
        end
    endfunction

    // Only byte lane 0 carries a register; other lanes are dropped
    always @* begin
        wr_sel = rbs_match(aw_addr_ff) & {NREG{wr_go && w_strb_ff[0]}};
        nxt_bresp = (|rbs_match(aw_addr_ff)) ? `RBS_RESP_OKAY : `RBS_RESP_SLVERR;
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `RBS_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= nxt_bresp;
        end else if (s_axi_bready_i) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    wire [8*NREG-1:0] reg_q;
    genvar gi;

    generate
        for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
            rbs_reg_byte #(
                .RST_VAL(`RBS_RST_VAL)
            ) u_reg (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .wr_en_i(wr_sel[gi]),
                .wr_data_i(w_data_ff[7:0]),
                .q_o(reg_q[8*gi+7:8*gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Read channel
    // ****************************************************************
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;
    reg [31:0] nxt_rdata;
    reg [NREG-1:0] rd_sel;
    integer ri;

    assign s_axi_arready_o = !rvalid_ff;

    // Bits above the byte read as zero
    always @* begin
        rd_sel = rbs_match(s_axi_araddr_i);
        nxt_rdata = 32'h0000_0000;
        for (ri = 0; ri < NREG; ri = ri + 1) begin
            if (rd_sel[ri]) begin
                nxt_rdata[7:0] = reg_q[8*ri +: 8];
            end
        end
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RBS_RESP_OKAY;
        end else if (s_axi_arvalid_i && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= (|rd_sel) ? `RBS_RESP_OKAY : `RBS_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign s_axi_rresp_o = rresp_ff;

    // ****************************************************************
    // Field decode
    // ****************************************************************
    wire [7:0] mem_buck_alt_setting;
    wire [7:0] io_buck_alt_setting;
    wire [7:0] peripheral_buck_alt_setting;
    wire [7:0] linear_reg_one_alt_setting;
    wire [7:0] linear_reg_two_alt_setting;
    wire [15:0] mem_mv;
    wire [15:0] io_mv;
    wire [15:0] periph_mv;
    wire [15:0] lin_one_mv;
    wire [15:0] lin_two_mv;

    assign mem_buck_alt_setting = reg_q[7:0];
    assign io_buck_alt_setting = reg_q[15:8];
    assign peripheral_buck_alt_setting = reg_q[23:16];
    assign linear_reg_one_alt_setting = reg_q[31:24];
    assign linear_reg_two_alt_setting = reg_q[39:32];

    rbs_code_decode #(
        .CODE_W(7),
        .BASE_MV(`RBS_BUCK_BASE_MV)
    ) u_mem_dec (
        .code_i(mem_buck_alt_setting[`RBS_BUCK_CODE_MSB:0]),
        .mv_o(mem_mv)
    );

    rbs_code_decode #(
        .CODE_W(7),
        .BASE_MV(`RBS_BUCK_BASE_MV)
    ) u_io_dec (
        .code_i(io_buck_alt_setting[`RBS_BUCK_CODE_MSB:0]),
        .mv_o(io_mv)
    );

    rbs_code_decode #(
        .CODE_W(7),
        .BASE_MV(`RBS_BUCK_BASE_MV)
    ) u_periph_dec (
        .code_i(peripheral_buck_alt_setting[`RBS_BUCK_CODE_MSB:0]),
        .mv_o(periph_mv)
    );

    // Bit 6 is reserved: stored and read back, never decoded
    rbs_code_decode #(
        .CODE_W(6),
        .BASE_MV(`RBS_LIN_BASE_MV)
    ) u_lin_one_dec (
        .code_i(linear_reg_one_alt_setting[`RBS_LIN_CODE_MSB:0]),
        .mv_o(lin_one_mv)
    );

    rbs_code_decode #(
        .CODE_W(6),
        .BASE_MV(`RBS_LIN_BASE_MV)
    ) u_lin_two_dec (
        .code_i(linear_reg_two_alt_setting[`RBS_LIN_CODE_MSB:0]),
        .mv_o(lin_two_mv)
    );

    // ****************************************************************
    // Regulator steering
    // ****************************************************************
    // Outputs registered so the regulators never see a decode glitch;
    // with the A set selected they hold zero and the A path governs
    always @(posedge mclk_i) begin
        if (rst_i) begin
            memory_buck_sleep_o <= 1'b0;
            memory_buck_mv_o <= 16'h0000;
            memory_buck_alt_active_o <= 1'b0;
            io_buck_sleep_o <= 1'b0;
            io_buck_mv_o <= 16'h0000;
            io_buck_alt_active_o <= 1'b0;
            peripheral_buck_sleep_o <= 1'b0;
            peripheral_buck_mv_o <= 16'h0000;
            peripheral_buck_alt_active_o <= 1'b0;
            linear_one_sleep_o <= 1'b0;
            linear_one_mv_o <= 16'h0000;
            linear_one_alt_active_o <= 1'b0;
            linear_two_sleep_o <= 1'b0;
            linear_two_mv_o <= 16'h0000;
            linear_two_alt_active_o <= 1'b0;
        end else if (alt_set_sel_i) begin
            memory_buck_sleep_o <= mem_buck_alt_setting[`RBS_SLEEP_BIT];
            memory_buck_mv_o <= mem_mv;
            memory_buck_alt_active_o <= 1'b1;
            io_buck_sleep_o <= io_buck_alt_setting[`RBS_SLEEP_BIT];
            io_buck_mv_o <= io_mv;
            io_buck_alt_active_o <= 1'b1;
            peripheral_buck_sleep_o <= peripheral_buck_alt_setting[`RBS_SLEEP_BIT];
            peripheral_buck_mv_o <= periph_mv;
            peripheral_buck_alt_active_o <= 1'b1;
            linear_one_sleep_o <= linear_reg_one_alt_setting[`RBS_SLEEP_BIT];
            linear_one_mv_o <= lin_one_mv;
            linear_one_alt_active_o <= 1'b1;
            linear_two_sleep_o <= linear_reg_two_alt_setting[`RBS_SLEEP_BIT];
            linear_two_mv_o <= lin_two_mv;
            linear_two_alt_active_o <= 1'b1;
        end else begin
            memory_buck_sleep_o <= 1'b0;
            memory_buck_mv_o <= 16'h0000;
            memory_buck_alt_active_o <= 1'b0;
            io_buck_sleep_o <= 1'b0;
            io_buck_mv_o <= 16'h0000;
            io_buck_alt_active_o <= 1'b0;
            peripheral_buck_sleep_o <= 1'b0;
            peripheral_buck_mv_o <= 16'h0000;
            peripheral_buck_alt_active_o <= 1'b0;
            linear_one_sleep_o <= 1'b0;
            linear_one_mv_o <= 16'h0000;
            linear_one_alt_active_o <= 1'b0;
            linear_two_sleep_o <= 1'b0;
            linear_two_mv_o <= 16'h0000;
            linear_two_alt_active_o <= 1'b0;
        end
    end

endmodule

/* File: tb/rbs_alt_setting_regs_chk.sv */
// Checker of bus timing and regulator outputs for the alternate setting bank
`timescale 1ns/10ps
`include "rbs_regs.vh"
module rbs_alt_setting_regs_chk #(
    parameter ADDR_W = 10
) (
    // Clock, reset and set select
    input logic mclk_i,
    input logic rst_i,
    input logic alt_set_sel_i,
    // Register bus
    input logic s_axi_awvalid_i,
    input logic s_axi_awready_o,
    input logic s_axi_wvalid_i,
    input logic s_axi_wready_o,
    input logic s_axi_bvalid_o,
    input logic s_axi_bready_i,
    input logic s_axi_arvalid_i,
    input logic s_axi_arready_o,
    input logic [31:0] s_axi_rdata_o,
    input logic s_axi_rvalid_o,
    input logic s_axi_rready_i,
    // Regulator outputs
    input logic memory_buck_sleep_o,
    input logic io_buck_sleep_o,
    input logic peripheral_buck_sleep_o,
    input logic linear_one_sleep_o,
    input logic linear_two_sleep_o,
    input logic [15:0] memory_buck_mv_o,
    input logic [15:0] io_buck_mv_o,
    input logic [15:0] peripheral_buck_mv_o,
    input logic [15:0] linear_one_mv_o,
    input logic [15:0] linear_two_mv_o,
    input logic memory_buck_alt_active_o,
    input logic linear_two_alt_active_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // ********************************
    // Properties
    // ********************************
    property p_mem_mv;
        memory_buck_mv_o != 16'h0000 |-> memory_buck_mv_o inside {[16'h0320:16'h0d0c]}
            && (memory_buck_mv_o - 16'h0320) % 16'h0014 == 16'h0000;
    endproperty
    a_mem_mv: assert property (p_mem_mv) else $error("memory buck level off");
    property p_io_pe_mv;
        io_buck_mv_o != 16'h0000 |-> io_buck_mv_o <= 16'h0d0c
            && peripheral_buck_mv_o >= 16'h0320 && peripheral_buck_mv_o <= 16'h0d0c;
    endproperty
    a_io_pe_mv: assert property (p_io_pe_mv) else $error("buck level off");
    property p_lin_mv;
        linear_one_mv_o != 16'h0000 |-> linear_one_mv_o inside {[16'h0258:16'h0744]}
            && (linear_two_mv_o - 16'h0258) % 16'h0014 == 16'h0000;
    endproperty
    a_lin_mv: assert property (p_lin_mv) else $error("linear level off");
    property p_sleep_gate;
        memory_buck_sleep_o | io_buck_sleep_o | peripheral_buck_sleep_o | linear_one_sleep_o
            | linear_two_sleep_o |-> $past(alt_set_sel_i);
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("sleep off set");
    property p_off;
        !alt_set_sel_i |=> !memory_buck_alt_active_o && memory_buck_mv_o == 16'h0000;
    endproperty
    a_off: assert property (p_off) else $error("output without set select");
    property p_on;
        alt_set_sel_i |=> memory_buck_alt_active_o && linear_two_alt_active_o;
    endproperty
    a_on: assert property (p_on) else $error("set select not applied");
    property p_r_lat;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_b_lat;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
            |-> ##[1:2] s_axi_bvalid_o;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    c_wr: cover property (s_axi_bvalid_o && s_axi_bready_i);
    c_rd_stall: cover property (s_axi_rvalid_o && !s_axi_rready_i);
    c_sleep: cover property (linear_two_sleep_o && memory_buck_sleep_o);
endmodule
bind rbs_alt_setting_regs rbs_alt_setting_regs_chk #(.ADDR_W(ADDR_W)) u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .alt_set_sel_i(alt_set_sel_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .memory_buck_sleep_o(memory_buck_sleep_o), .io_buck_sleep_o(io_buck_sleep_o),
    .peripheral_buck_sleep_o(peripheral_buck_sleep_o),
    .linear_one_sleep_o(linear_one_sleep_o), .linear_two_sleep_o(linear_two_sleep_o),
    .memory_buck_mv_o(memory_buck_mv_o), .io_buck_mv_o(io_buck_mv_o),
    .peripheral_buck_mv_o(peripheral_buck_mv_o), .linear_one_mv_o(linear_one_mv_o),
    .linear_two_mv_o(linear_two_mv_o),
    .memory_buck_alt_active_o(memory_buck_alt_active_o),
    .linear_two_alt_active_o(linear_two_alt_active_o));

/* File: tb/rbs_alt_setting_regs_bench.sv */
// Self-checking bench for the alternate setting register bank
`timescale 1ns/10ps
`include "rbs_regs.vh"
module rbs_alt_setting_regs_bench;
    // ********************************
    // Signals and design
    // ********************************
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic alt_set_sel_i = 1'b0;
    logic [9:0] s_axi_awaddr_i = 10'h000, s_axi_araddr_i = 10'h000;
    logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_i = 4'h0;
    wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
    wire [31:0] s_axi_rdata_o;
    wire [4:0] slp, act;
    wire [15:0] mv [5];
    int err_total = 0;
    int n_checks = 0;
    always #10 mclk_i = ~mclk_i;
    rbs_alt_setting_regs #(.ADDR_W(10)) rbs_alt_setting_regs_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .alt_set_sel_i(alt_set_sel_i),
        .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awprot_i(s_axi_awprot_i),
        .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
        .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
        .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
        .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
        .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
        .s_axi_arprot_i(s_axi_arprot_i), .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i),
        .memory_buck_sleep_o(slp[0]), .memory_buck_mv_o(mv[0]), .memory_buck_alt_active_o(act[0]),
        .io_buck_sleep_o(slp[1]), .io_buck_mv_o(mv[1]), .io_buck_alt_active_o(act[1]),
        .peripheral_buck_sleep_o(slp[2]), .peripheral_buck_mv_o(mv[2]),
        .peripheral_buck_alt_active_o(act[2]),
        .linear_one_sleep_o(slp[3]), .linear_one_mv_o(mv[3]), .linear_one_alt_active_o(act[3]),
        .linear_two_sleep_o(slp[4]), .linear_two_mv_o(mv[4]), .linear_two_alt_active_o(act[4]));
    // ********************************
    // Shared tasks
    // ********************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("Checks made %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bounded wait: a hung handshake ends the run
    task automatic tick(inout int n);
        @(posedge mclk_i);
        n++;
        if (n > 60) begin
            err_total++;
            $display("BAD %0t handshake timeout", $time);
            print_verdict;
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        logic aw, w;
        int n;
        aw = 1'b0;
        w = 1'b0;
        n = 0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'hab_cdef, d};
        s_axi_wstrb_i <= st;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        while (!(aw && w)) begin
            tick(n);
            if (!aw && s_axi_awready_o) begin
                aw = 1'b1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (!w && s_axi_wready_o) begin
                w = 1'b1;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        do tick(n); while (!s_axi_bvalid_o);
        chk(s_axi_bresp_o, er);
        s_axi_bready_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er,
                      input int stall);
        int n;
        n = 0;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= (stall == 0);
        do tick(n); while (!s_axi_arready_o);
        s_axi_arvalid_i <= 1'b0;
        do tick(n); while (!s_axi_rvalid_o);
        if (stall > 0) begin
            repeat (stall) tick(n);
            s_axi_rready_i <= 1'b1;
            tick(n);
        end
        chk(s_axi_rdata_o, e);
        chk(s_axi_rresp_o, er);
        s_axi_rready_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    function automatic logic [15:0] exp_mv(input int i, input logic [7:0] v);
        return (i < 3) ? 16'h0320 + 16'h0014 * v[6:0] : 16'h0258 + 16'h0014 * v[5:0];
    endfunction
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_regs;
        for (int i = 0; i < 5; i++) rd(10'h2dc + 4 * i, 32'h0000_0000, 2'b00, i);
        for (int i = 0; i < 5; i++) wr(10'h2dc + 4 * i, 8'h5a + i, 4'h1, 2'b00);
        for (int i = 0; i < 5; i++) rd(10'h2dc + 4 * i, 8'h5a + i, 2'b00, 0);
        wr(10'h2e0, 8'h00, 4'he, 2'b00);
        rd(10'h2e0, 8'h5b, 2'b00, 2);
        wr(10'h2f0, 8'h11, 4'h1, 2'b10);
        rd(10'h2f0, 32'h0000_0000, 2'b10, 0);
        rd(10'h2ec, 8'h5e, 2'b00, 0);
        $display("t_regs done");
    endtask
    task automatic t_decode;
        logic [7:0] tbl [4] = '{8'h00, 8'hff, 8'h4a, 8'h32};
        alt_set_sel_i <= 1'b1;
        foreach (tbl[k]) begin
            for (int i = 0; i < 5; i++) wr(10'h2dc + 4 * i, tbl[k], 4'h1, 2'b00);
            for (int i = 0; i < 5; i++) begin
                chk(slp[i], tbl[k][7]);
                chk(mv[i], exp_mv(i, tbl[k]));
                chk(act[i], 1'b1);
            end
            rd(10'h2e8, tbl[k], 2'b00, 0);
        end
        $display("t_decode done");
    endtask
    task automatic t_gate;
        alt_set_sel_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk({slp, act}, 10'h000);
        for (int i = 0; i < 5; i++) chk(mv[i], 16'h0000);
        alt_set_sel_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        chk({slp, act}, 10'h01f);
        chk(mv[2], 16'h0708);
        $display("t_gate done");
    endtask
    task automatic t_reset;
        rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk({slp, act}, 10'h000);
        chk(mv[1], 16'h0000);
        rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk({slp, act}, 10'h01f);
        chk(mv[0], 16'h0320);
        chk(mv[3], 16'h0258);
        for (int i = 0; i < 5; i++) rd(10'h2dc + 4 * i, 32'h0000_0000, 2'b00, 0);
        $display("t_reset done");
    endtask
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        t_regs;
        t_decode;
        t_gate;
        t_reset;
        print_verdict;
    end
endmodule
